// File: lvd_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the supply monitor.
// Assumes: 32-bit APB data, byte addresses.
// Notes: Definitions only.
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

`define LVD_CTRL_OFFSET 16'h1400
`define LVD_IRQ_STATUS_OFFSET 16'h1410
`define LVD_IRQ_MASK_OFFSET 16'h1414
`define LVD_CTRL_RESET 32'h0000_0000
`define LVD_BIT_ENABLE 15
`define LVD_BIT_HALT_IDLE 13
`define LVD_BIT_DIRECTION 11
`define LVD_BIT_BG_STABLE 10
`define LVD_BIT_REFS_STABLE 9
`define LVD_BIT_EVENT 8
`define LVD_BIT_OUT_GATE 7
`define LVD_LEVEL_MSB 3
`define LVD_NMI_BIT 18
`define LVD_IRQ_BIT_EVENT 0
`define LVD_IRQ_BIT_REFS 1
`define LVD_IRQ_WIDTH 2
`define LVD_HYST_NS 1000
`define LVD_CLK_MHZ 40
`define LVD_HYST_CYCLES ((`LVD_HYST_NS * `LVD_CLK_MHZ + 999) / 1000)

`endif

// File: lvd_pkg.sv
// Purpose: Types shared by the supply monitor files.
// Assumes: Nothing beyond the defines header.
// Notes: Modes follow the system power state.
package lvd_pkg;
  typedef enum logic [1:0] {
    mode_run,
    mode_idle,
    mode_sleep,
    mode_freeze
  } sys_mode_t;
  typedef enum {
    det_clear,
    det_tripped
  } det_state_t;
endpackage

// File: lvd_sync_bit.sv
// Purpose: Two flip-flop synchroniser for one analog status level.
// Assumes: Single clock pclk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module lvd_sync_bit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: lvd_hysteresis.sv
// Purpose: Debounced trip state with a hold-off time against chatter.
// Assumes: compare input already synchronised and gated; qualification arrives on its own input.
// Notes: Leaves the tripped state after the hold-off elapses clear, or at once when not qualified.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
module lvd_hysteresis
  import lvd_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `LVD_HYST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic qualified,
  input wire logic compare,
  output logic tripped
);
  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_MAX = CW'(HOLD_CYCLES);
  det_state_t state;
  logic [CW-1:0] count;

  // A trip is entered at once, but released only after the compare has stayed clear or qualification drops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= det_clear;
      count <= '0;
    end else if (!qualified) begin
      state <= det_clear;
      count <= '0;
    end else if (run) begin
      case (state)
        det_clear: begin
          count <= '0;
          if (compare) begin
            state <= det_tripped;
          end
        end
        det_tripped: begin
          if (compare) begin
            count <= '0;
          end else if (count >= HOLD_MAX - CW'(1)) begin
            state <= det_clear;
            count <= '0;
          end else begin
            count <= count + CW'(1);
          end
        end
        default: begin
          state <= det_clear;
          count <= '0;
        end
      endcase
    end
  end

  assign tripped = (state == det_tripped);
endmodule
`default_nettype wire

// File: lvd_control.sv
// Purpose: Control register, event logic and interrupts of the supply monitor.
// Assumes: APB slave on pclk; analog comparator and references outside.
// Notes: A raw comparator path keeps events alive while clocks are stopped.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"
// Functional notes
// - Low supply raises the NMI event on bit 18 of the NMI control register.
// - A low-voltage event blocks flash programming while present.
// - In Sleep, an enabled detector still raises its event without clock.
// - In Idle, run when halt bit is 0; else act as in Sleep.
// - Freeze holds outputs, makes no events, keeps register access.
// - Enable bit powers up detector and references and enables detection.
// - Direction bit: 1 fires at or above limit, 0 at or below.
// - Bit 10 shows band-gap stability, driven by hardware.
// - Bit 9 shows all internal references stable, driven by hardware.
// - Bit 8 shows the event interrupt active, driven by hardware.
// - Output gate bit 0 blocks comparator, 1 passes; set only.
// - Four-bit level field selects trip points, codes 4 to 7.
// - Bits 6-4 and all unimplemented bits read as zero.
// - Falling or rising supply by the direction bit, with hysteresis against chatter (code: only in Run and in Idle with halt bit 0; the raw Sleep path has none).
module lvd_control
  import lvd_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `LVD_HYST_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] sys_mode,
  input wire logic cmp_below,
  input wire logic cmp_above,
  input wire logic bandgap_ok,
  input wire logic refs_ok,
  output logic monitor_power_en,
  output logic [3:0] trip_level_select,
  output logic nmi_event,
  output logic [31:0] nmi_control_register,
  output logic flash_prog_inhibit,
  output logic irq
);
  logic detector_enable;
  logic halt_when_idle;
  logic trip_direction_select;
  logic comparator_output_gate;
  logic [3:0] level;
  logic bandgap_stable_flag;
  logic internal_refs_stable_flag;
  logic event_flag;
  logic [`LVD_IRQ_WIDTH-1:0] irq_status;
  logic [`LVD_IRQ_WIDTH-1:0] irq_mask;
  logic bg_sync;
  logic refs_sync;
  logic below_sync;
  logic above_sync;
  logic run;
  logic frozen;
  logic qualified;
  logic compare;
  logic tripped;
  logic raw_trip;
  logic live_event;
  logic refs_prev;
  logic setup;
  logic wr_access;
  logic ctrl_hit;
  logic status_hit;
  logic mask_hit;
  logic [31:0] ctrl_value;
  logic [`LVD_IRQ_WIDTH-1:0] irq_sources;

  lvd_sync_bit sync_bg (
    .pclk(pclk), .presetn(presetn), .async_in(bandgap_ok), .sync_out(bg_sync)
  );
  lvd_sync_bit sync_refs (
    .pclk(pclk), .presetn(presetn), .async_in(refs_ok), .sync_out(refs_sync)
  );
  lvd_sync_bit sync_below (
    .pclk(pclk), .presetn(presetn), .async_in(cmp_below), .sync_out(below_sync)
  );
  lvd_sync_bit sync_above (
    .pclk(pclk), .presetn(presetn), .async_in(cmp_above), .sync_out(above_sync)
  );

  // Idle with the halt bit set behaves exactly like Sleep.
  assign frozen = (sys_mode_t'(sys_mode) == mode_freeze);
  assign run = (sys_mode_t'(sys_mode) == mode_run) ||
               ((sys_mode_t'(sys_mode) == mode_idle) && !halt_when_idle);
  assign qualified = detector_enable && internal_refs_stable_flag;
  // The gate blocks the comparator when clear; direction picks the threshold side.
  assign compare = comparator_output_gate &&
                   (trip_direction_select ? above_sync : below_sync);

  lvd_hysteresis #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) hyst (
    .pclk(pclk),
    .presetn(presetn),
    .run(run && !frozen),
    .qualified(qualified),
    .compare(compare),
    .tripped(tripped)
  );

  // Clockless path: the analog level itself carries the event while clocks are stopped.
  assign raw_trip = detector_enable && comparator_output_gate &&
                    (trip_direction_select ? cmp_above : cmp_below);
  assign live_event = run ? tripped : raw_trip;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign ctrl_hit = (paddr == `LVD_CTRL_OFFSET);
  assign status_hit = (paddr == `LVD_IRQ_STATUS_OFFSET);
  assign mask_hit = (paddr == `LVD_IRQ_MASK_OFFSET);

  // Status flags follow hardware; bus writes never touch them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_stable_flag <= 1'b0;
      internal_refs_stable_flag <= 1'b0;
      event_flag <= 1'b0;
    end else if (!frozen) begin
      bandgap_stable_flag <= detector_enable && bg_sync;
      internal_refs_stable_flag <= detector_enable && refs_sync;
      event_flag <= qualified && live_event;
    end
  end

  // Software-owned fields; register access stays live even in Freeze.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detector_enable <= 1'b0;
      halt_when_idle <= 1'b0;
      trip_direction_select <= 1'b0;
      comparator_output_gate <= 1'b0;
      level <= 4'h0;
    end else if (wr_access && ctrl_hit) begin
      if (pstrb[1]) begin
        detector_enable <= pwdata[`LVD_BIT_ENABLE];
        halt_when_idle <= pwdata[`LVD_BIT_HALT_IDLE];
        trip_direction_select <= pwdata[`LVD_BIT_DIRECTION];
      end
      if (pstrb[0]) begin
        comparator_output_gate <= comparator_output_gate | pwdata[`LVD_BIT_OUT_GATE];
        level <= pwdata[`LVD_LEVEL_MSB:0];
      end
    end
  end

  assign ctrl_value = {16'h0000,
                       detector_enable, 1'b0, halt_when_idle, 1'b0,
                       trip_direction_select, bandgap_stable_flag,
                       internal_refs_stable_flag, event_flag,
                       comparator_output_gate, 3'h0, level};

  // Interrupt sources: event rising and references becoming stable.
  assign irq_sources = {internal_refs_stable_flag && !refs_prev,
                        qualified && live_event && !event_flag};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refs_prev <= 1'b0;
    end else begin
      refs_prev <= internal_refs_stable_flag;
    end
  end

  // A new event in the clearing cycle wins over the write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_access && status_hit && pstrb[0]) begin
        irq_status <= (irq_status & ~pwdata[`LVD_IRQ_WIDTH-1:0]) |
                      (frozen ? '0 : irq_sources);
      end else if (!frozen) begin
        irq_status <= irq_status | irq_sources;
      end
      if (wr_access && mask_hit && pstrb[0]) begin
        irq_mask <= pwdata[`LVD_IRQ_WIDTH-1:0];
      end
    end
  end

  // No wait state: the answer is registered from the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !(ctrl_hit || status_hit || mask_hit);
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (ctrl_hit) begin
        prdata <= ctrl_value;
      end else if (status_hit) begin
        prdata <= {30'h0, irq_status};
      end else if (mask_hit) begin
        prdata <= {30'h0, irq_mask};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Outputs hold their values through Freeze.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_power_en <= 1'b0;
      trip_level_select <= 4'h0;
      nmi_event <= 1'b0;
      nmi_control_register <= 32'h0000_0000;
      flash_prog_inhibit <= 1'b0;
      irq <= 1'b0;
    end else if (!frozen) begin
      monitor_power_en <= detector_enable;
      trip_level_select <= level;
      nmi_event <= qualified && live_event;
      nmi_control_register <= 32'(qualified && live_event) << `LVD_NMI_BIT;
      flash_prog_inhibit <= qualified && live_event;
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// File: lvd_control_checker.sv
// Purpose: Port assertions for the supply monitor control block.
// Assumes: One clock pclk, asynchronous active-low reset presetn.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module lvd_control_checker #(
  parameter int unsigned HOLD_CYCLES = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] sys_mode,
  input wire logic monitor_power_en,
  input wire logic [3:0] trip_level_select,
  input wire logic nmi_event,
  input wire logic [31:0] nmi_control_register,
  input wire logic flash_prog_inhibit
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic ctl = (paddr == 16'h1400);
  wire logic frz = (sys_mode == 2'd3);
  wire logic wr = psel && penable && pready && pwrite && ctl;
  chk_inhibit_follows: assert property (flash_prog_inhibit == nmi_event)
    else $error("Flash inhibit differs from the event.");
  chk_nmi_bit: assert property (nmi_control_register == {13'h0, nmi_event, 18'h0})
    else $error("NMI register does not carry the event alone.");
  chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("Ready is not a one-cycle answer.");
  chk_unmapped_err: assert property (
    psel && !penable && !(paddr inside {16'h1400, 16'h1410, 16'h1414}) |=> pslverr && prdata == 0)
    else $error("Unmapped access not refused.");
  chk_reserved_zero: assert property (
    pready && !pwrite && ctl |-> (prdata & 32'hffff_5070) == 32'h0)
    else $error("Unimplemented control bits read nonzero.");
  chk_freeze_hold: assert property (
    frz && $past(frz) |-> $stable(nmi_event) && $stable(trip_level_select))
    else $error("Outputs moved during freeze.");
  chk_event_enabled: assert property ($rose(nmi_event) |-> $past(monitor_power_en))
    else $error("Event rose while disabled.");
  // The field lands at the write edge and reaches its output one edge later.
  chk_level_write: assert property (
    wr && pstrb[0] && !frz |-> ##2 ($past(frz) || trip_level_select == $past(pwdata[3:0], 2)))
    else $error("Level output did not follow the write.");
  chk_enable_write: assert property (
    wr && pstrb[1] && !frz |-> ##2 ($past(frz) || monitor_power_en == $past(pwdata[15], 2)))
    else $error("Power enable did not follow the write.");
  chk_flags_off: assert property (
    pready && !pwrite && ctl && !monitor_power_en && !$past(monitor_power_en, 2) |->
    prdata[10:9] == 2'b00)
    else $error("Stability flags set while powered down.");
endmodule
`default_nettype wire

// File: lvd_analog_model.sv
// Purpose: Behavioural comparator and reference of the supply monitor.
// Assumes: Supply level is given by the bench as a low flag.
// Notes: An unpowered comparator drives both outputs low.
`timescale 1ns/1ps
`default_nettype none
module lvd_analog_model (
  input wire logic pclk,
  input wire logic power_en,
  input wire logic supply_low,
  output logic cmp_below,
  output logic cmp_above,
  output logic bandgap_ok,
  output logic refs_ok
);
  int unsigned settle = 0;
  // References need a few cycles to settle after power-up, so flags must lag.
  always @(posedge pclk) begin
    if (!power_en) settle <= 0;
    else if (settle < 8) settle <= settle + 1;
  end
  assign bandgap_ok = (settle >= 3);
  assign refs_ok = (settle >= 6);
  assign cmp_below = power_en && supply_low;
  assign cmp_above = power_en && !supply_low;
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench of the supply monitor control block.
// Assumes: APB master tasks and a register model kept here.
// Notes: Hold time shortened to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned HOLD = 2;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low = 0, err;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, nmi_control_register, rd, w, ctrl_m = 0;
  logic [3:0] pstrb = 0, trip_level_select;
  logic [1:0] sys_mode = 0;
  logic pready, pslverr, cmp_below, cmp_above, bandgap_ok, refs_ok;
  logic monitor_power_en, nmi_event, flash_prog_inhibit, irq;
  int n_mismatch = 0, tests_run = 0, seed = 6852;
  initial forever #12.5 pclk = ~pclk;
  lvd_control #(.HOLD_CYCLES(HOLD)) lvd_control_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_mode(sys_mode), .cmp_below(cmp_below), .cmp_above(cmp_above),
    .bandgap_ok(bandgap_ok), .refs_ok(refs_ok), .monitor_power_en(monitor_power_en),
    .trip_level_select(trip_level_select), .nmi_event(nmi_event),
    .nmi_control_register(nmi_control_register),
    .flash_prog_inhibit(flash_prog_inhibit), .irq(irq));
  lvd_analog_model lvd_analog_model_i (.pclk(pclk), .power_en(monitor_power_en),
    .supply_low(low), .cmp_below(cmp_below), .cmp_above(cmp_above),
    .bandgap_ok(bandgap_ok), .refs_ok(refs_ok));
  task end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 16) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask
  // Only the gate bit is sticky; flags show while powered.
  task wr_ctrl(input logic [31:0] d);
    apb(1, 16'h1400, d);
    ctrl_m = (d & 32'h0000_a80f) | ((ctrl_m | d) & 32'h80);
  endtask
  function automatic logic [31:0] exp_ctrl(input logic ev);
    return ctrl_m | (ctrl_m[15] ? 32'h600 : 32'h0) | {23'h0, ev, 8'h0};
  endfunction
  task wait_nmi(input logic v);
    int i;
    for (i = 0; i < 200 && nmi_event !== v; i++) @(posedge pclk);
    chk("nmi_event", {31'h0, nmi_event}, {31'h0, v});
    if (nmi_event !== v) end_sim();
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rdchk("ctrl reset", 16'h1400, 32'h0);
    rdchk("mask reset", 16'h1414, 32'h0);
    apb(1, 16'h1404, 32'hffff_ffff);
    chk("unmapped", {31'h0, err}, 32'h1);
    w = $random(seed);
    wr_ctrl(w & 32'hffff_7fff);
    rdchk("ctrl random", 16'h1400, exp_ctrl(0));
    wr_ctrl(32'h80);
    wr_ctrl(32'h0);
    rdchk("gate sticky", 16'h1400, exp_ctrl(0));
    for (int k = 4; k < 8; k++) begin
      wr_ctrl(32'h8080 | k);
      // The level output is registered from the field, one edge after the write.
      repeat (2) @(posedge pclk);
      chk("level", {28'h0, trip_level_select}, k);
      chk("power on", {31'h0, monitor_power_en}, 32'h1);
    end
    $display("Register tests done");
    repeat (20) @(posedge pclk);
    rdchk("flags", 16'h1400, exp_ctrl(0));
    low <= 1;
    wait_nmi(1);
    chk("inhibit", {31'h0, flash_prog_inhibit}, 32'h1);
    chk("nmi reg", nmi_control_register, 32'h0004_0000);
    rdchk("event bit", 16'h1400, exp_ctrl(1));
    rdchk("status", 16'h1410, 32'h3);
    apb(1, 16'h1414, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq on", {31'h0, irq}, 32'h1);
    apb(1, 16'h1410, 32'h3);
    rdchk("status clr", 16'h1410, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
    low <= 0;
    wait_nmi(0);
    wr_ctrl(32'h8887);
    wait_nmi(1);
    wr_ctrl(32'h8087);
    wait_nmi(0);
    $display("Event tests done");
    sys_mode <= 2'd3;
    low <= 1;
    repeat (30) @(posedge pclk);
    chk("freeze", {31'h0, nmi_event}, 32'h0);
    wr_ctrl(32'h8086);
    rdchk("freeze rw", 16'h1400, exp_ctrl(0));
    sys_mode <= 2'd0;
    wait_nmi(1);
    low <= 0;
    wait_nmi(0);
    sys_mode <= 2'd1;
    low <= 1;
    wait_nmi(1);
    low <= 0;
    wait_nmi(0);
    sys_mode <= 2'd0;
    wr_ctrl(32'ha086);
    for (int m = 1; m < 3; m++) begin
      sys_mode <= m[1:0];
      low <= 1;
      wait_nmi(1);
      low <= 0;
      sys_mode <= 2'd0;
      wait_nmi(0);
    end
    wr_ctrl(32'h0);
    rdchk("disabled", 16'h1400, exp_ctrl(0));
    chk("power off", {31'h0, monitor_power_en}, 32'h0);
    low <= 1;
    repeat (30) @(posedge pclk);
    chk("no event off", {31'h0, nmi_event}, 32'h0);
    chk("no inhibit off", {31'h0, flash_prog_inhibit}, 32'h0);
    $display("Mode tests done");
    end_sim();
  end
endmodule
bind lvd_control lvd_control_checker #(.HOLD_CYCLES(HOLD_CYCLES)) lvd_control_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys_mode(sys_mode), .monitor_power_en(monitor_power_en),
  .trip_level_select(trip_level_select), .nmi_event(nmi_event),
  .nmi_control_register(nmi_control_register), .flash_prog_inhibit(flash_prog_inhibit));
`default_nettype wire
